/* antenna_sense_model.sv */
`timescale 1ns/1ps
module antenna_sense_model (
  input  wire logic clock,
  input  wire logic antenna_power_off,
  input  wire logic short_fault,
  input  wire logic open_fault,
  input  wire logic slow,
  output logic      antenna_short_in,
  output logic      antenna_present_in
);
  logic [1:0] powered_hist;

  // supply current takes a couple of cycles to build up in slow mode
  always_ff @(posedge clock) begin
    powered_hist <= {powered_hist[0], !antenna_power_off};
  end

  // a short sinks the line only while powered; otherwise the pull-up wins
  assign antenna_short_in = !(short_fault && !antenna_power_off && (!slow || powered_hist[1]));
  // pull-up reads high unless the antenna draws no current
  assign antenna_present_in = !open_fault;
endmodule

/* antenna_supervisor.sv */
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - no status reports until voltage control enable is set
// - voltage control enable activates power control and reports power on
// - power-off output active high; low keeps antenna powered
// - short detection enable activates short-input monitoring
// - short input active low, pulled up; external circuit pulls low on short
// - short without recovery reports SHORT but keeps antenna powered
// - SHORT stays latched until recovery, power cycle, or short-detect toggle
// - recovery enable activates the short recovery feature
// - with recovery, short reports SHORT, power OFF, power-off output high
// - after timeout, re-test the short by driving power-off low
// - short gone on re-test gives status OK with power on
// - open detection enable monitors active-high pulled-up present input
// - open detection with present input low reports OPEN
// - present input high or floating reports OK
// - at startup report enabled features, then INIT, then OK
// - connected antenna reads OK after power-up via status query
module antenna_supervisor #(
  parameter int RECOVERY_CYCLES = antenna_supervisor_pkg::RECOVERY_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        antenna_short_in,
  input  wire logic        antenna_present_in,
  output logic             antenna_power_off,
  output logic             interrupt
);
  localparam int EW = antenna_supervisor_pkg::EVENT_WIDTH;

  // reset and pins
  logic        rst_meta;
  logic        rst_sync_b;
  logic [2:0]  short_sync;
  logic [2:0]  present_sync;
  // agreed pin levels
  logic        short_seen;
  logic        present_seen;

  // registers
  logic [3:0]  config_bits;
  logic [EW-1:0] event_status;
  logic [EW-1:0] event_mask;
  logic [EW-1:0] event_set;
  logic [EW-1:0] event_clear;

  // status and recovery
  antenna_supervisor_pkg::antenna_status_type status;
  antenna_supervisor_pkg::antenna_status_type next_status;
  antenna_supervisor_pkg::recovery_state_type rec_state;
  logic [31:0] rec_count;
  logic [1:0]  init_count;
  logic        reports_on;
  logic        short_enable_d;
  // read-visible copies
  logic        power_on;
  logic [7:0]  report_count;

  // write holding
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  // config fields
  wire voltage_en  = config_bits[antenna_supervisor_pkg::CFG_VOLTAGE_BIT];
  wire short_en    = config_bits[antenna_supervisor_pkg::CFG_SHORT_BIT];
  wire recovery_en = config_bits[antenna_supervisor_pkg::CFG_RECOVERY_BIT];
  wire open_en     = config_bits[antenna_supervisor_pkg::CFG_OPEN_BIT];

  // reset release through two flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // pin synchronisers; first stage read only by the second
  // ones preset matches idle level
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      short_sync   <= 3'h7;
      present_sync <= 3'h7;
    end else begin
      short_sync   <= {short_sync[1:0], antenna_short_in};
      present_sync <= {present_sync[1:0], antenna_present_in};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      short_seen   <= 1'b0;
      present_seen <= 1'b1;
    end else begin
      if (short_sync[1] == short_sync[2]) begin
        short_seen <= ~short_sync[2];
      end
      if (present_sync[1] == present_sync[2]) begin
        present_seen <= present_sync[2];
      end
    end
  end

  // axi write channel: address and data taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= antenna_supervisor_pkg::AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // read-only offsets refuse writes
        if (aw_addr == antenna_supervisor_pkg::CONFIG_OFFSET ||
            aw_addr == antenna_supervisor_pkg::EVENT_OFFSET ||
            aw_addr == antenna_supervisor_pkg::MASK_OFFSET) begin
          s_axi_bresp <= antenna_supervisor_pkg::AXI_OKAY;
        end else begin
          s_axi_bresp <= antenna_supervisor_pkg::AXI_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // config and mask registers, low byte lane only
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      config_bits <= antenna_supervisor_pkg::CONFIG_RESET;
      event_mask  <= '0;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == antenna_supervisor_pkg::CONFIG_OFFSET) begin
        config_bits <= w_data[3:0];
      end else if (aw_addr == antenna_supervisor_pkg::MASK_OFFSET) begin
        event_mask <= w_data[EW-1:0];
      end
    end
  end

  // startup: INIT for a few cycles once control is on, then live status
  // delayed enable sees a short-detect toggle
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      init_count     <= 2'h0;
      reports_on     <= 1'b0;
      short_enable_d <= 1'b0;
    end else begin
      short_enable_d <= short_en;
      if (!voltage_en) begin
        init_count <= 2'h0;
        reports_on <= 1'b0;
      end else if (init_count != 2'(antenna_supervisor_pkg::INIT_CYCLES)) begin
        init_count <= init_count + 2'h1;
      end else begin
        reports_on <= 1'b1;
      end
    end
  end

  // recovery sequence: power off, wait timeout, re-test
  // dropped enables restore power
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rec_state <= antenna_supervisor_pkg::REC_IDLE;
      rec_count <= 32'h0000_0000;
    end else if (!recovery_en || !short_en || !reports_on) begin
      rec_state <= antenna_supervisor_pkg::REC_IDLE;
      rec_count <= 32'h0000_0000;
    end else begin
      case (rec_state)
        antenna_supervisor_pkg::REC_IDLE: begin
          rec_count <= 32'h0000_0000;
          if (short_seen) begin
            rec_state <= antenna_supervisor_pkg::REC_OFF;
          end
        end
        antenna_supervisor_pkg::REC_OFF: begin
          if (rec_count == 32'(RECOVERY_CYCLES - 1)) begin
            rec_count <= 32'h0000_0000;
            rec_state <= antenna_supervisor_pkg::REC_RETEST;
          end else begin
            rec_count <= rec_count + 32'h1;
          end
        end
        antenna_supervisor_pkg::REC_RETEST: begin
          // let the sense circuit and synchroniser settle after power returns
          if (rec_count == 32'(antenna_supervisor_pkg::RETEST_SETTLE + 3)) begin
            rec_count <= 32'h0000_0000;
            if (short_seen) begin
              rec_state <= antenna_supervisor_pkg::REC_OFF;
            end else begin
              rec_state <= antenna_supervisor_pkg::REC_IDLE;
            end
          end else begin
            rec_count <= rec_count + 32'h1;
          end
        end
        default: rec_state <= antenna_supervisor_pkg::REC_IDLE;
      endcase
    end
  end

  // status evaluation; short latches, open and ok follow the pin
  // a short outranks an open
  always_comb begin
    next_status = status;
    if (!reports_on) begin
      next_status = antenna_supervisor_pkg::ANT_INIT;
    end else if (status == antenna_supervisor_pkg::ANT_SHORT) begin
      if (!short_en || !short_enable_d) begin
        next_status = antenna_supervisor_pkg::ANT_OK;
      end else if (rec_state == antenna_supervisor_pkg::REC_RETEST &&
                   rec_count == 32'(antenna_supervisor_pkg::RETEST_SETTLE + 3) &&
                   !short_seen) begin
        next_status = antenna_supervisor_pkg::ANT_OK;
      end
    end else if (short_en && short_seen) begin
      next_status = antenna_supervisor_pkg::ANT_SHORT;
    end else if (open_en && !present_seen) begin
      next_status = antenna_supervisor_pkg::ANT_OPEN;
    end else begin
      next_status = antenna_supervisor_pkg::ANT_OK;
    end
  end

  // status register
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      status <= antenna_supervisor_pkg::ANT_INIT;
    end else begin
      status <= next_status;
    end
  end

  // power output: off only while recovery holds the supply down
  // pin and power bit move together while voltage control is on
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      antenna_power_off <= 1'b0;
      power_on          <= 1'b0;
    end else begin
      antenna_power_off <= (rec_state == antenna_supervisor_pkg::REC_OFF);
      power_on          <= voltage_en &&
                           (rec_state != antenna_supervisor_pkg::REC_OFF);
    end
  end

  // sticky events, set wins over write-one-to-clear
  always_comb begin
    event_set = '0;
    event_set[antenna_supervisor_pkg::EV_STATUS_CHANGE] = reports_on && (next_status != status);
    event_set[antenna_supervisor_pkg::EV_SHORT] = reports_on && (next_status != status) &&
      (next_status == antenna_supervisor_pkg::ANT_SHORT);
    event_set[antenna_supervisor_pkg::EV_OPEN] = reports_on && (next_status != status) &&
      (next_status == antenna_supervisor_pkg::ANT_OPEN);
    event_set[antenna_supervisor_pkg::EV_RECOVERED] =
      (status == antenna_supervisor_pkg::ANT_SHORT) &&
      (next_status == antenna_supervisor_pkg::ANT_OK);
    event_clear = '0;
    if (do_write && w_strb[0] && aw_addr == antenna_supervisor_pkg::EVENT_OFFSET) begin
      event_clear = w_data[EW-1:0];
    end
  end

  // interrupt rises with its event
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      event_status <= '0;
      interrupt    <= 1'b0;
      report_count <= 8'h00;
    end else begin
      event_status <= (event_status & ~event_clear) | event_set;
      interrupt    <= |(((event_status & ~event_clear) | event_set) & event_mask);
      // counts status reports issued; wraps
      if (event_set[antenna_supervisor_pkg::EV_STATUS_CHANGE]) begin
        report_count <= report_count + 8'h01;
      end
    end
  end

  // axi read channel, one outstanding read
  // unmapped reads give zero with SLVERR
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= antenna_supervisor_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= antenna_supervisor_pkg::AXI_OKAY;
        s_axi_rdata   <= 32'h0000_0000;
        if (s_axi_araddr == antenna_supervisor_pkg::CONFIG_OFFSET) begin
          s_axi_rdata[3:0] <= config_bits;
        end else if (s_axi_araddr == antenna_supervisor_pkg::STATUS_OFFSET) begin
          s_axi_rdata[antenna_supervisor_pkg::STATUS_STATE_LSB +: 2] <= status;
          s_axi_rdata[antenna_supervisor_pkg::STATUS_POWER_BIT] <= power_on;
          s_axi_rdata[antenna_supervisor_pkg::STATUS_VALID_BIT] <= reports_on;
        end else if (s_axi_araddr == antenna_supervisor_pkg::EVENT_OFFSET) begin
          s_axi_rdata[EW-1:0] <= event_status;
        end else if (s_axi_araddr == antenna_supervisor_pkg::MASK_OFFSET) begin
          s_axi_rdata[EW-1:0] <= event_mask;
        end else if (s_axi_araddr == antenna_supervisor_pkg::FEATURE_OFFSET) begin
          // feature report; power-down-on-short rides with recovery
          s_axi_rdata[antenna_supervisor_pkg::FEAT_CONTROL_BIT]  <= voltage_en;
          s_axi_rdata[antenna_supervisor_pkg::FEAT_SHORT_BIT]    <= voltage_en && short_en;
          s_axi_rdata[antenna_supervisor_pkg::FEAT_OPEN_BIT]     <= voltage_en && open_en;
          s_axi_rdata[antenna_supervisor_pkg::FEAT_FEATURE_POWER_DOWN_ON_SHORT_BIT]     <= voltage_en && recovery_en;
          s_axi_rdata[antenna_supervisor_pkg::FEAT_RECOVERY_BIT] <= voltage_en && recovery_en;
        end else if (s_axi_araddr == antenna_supervisor_pkg::REPORT_OFFSET) begin
          s_axi_rdata[7:0] <= report_count;
        end else begin
          s_axi_rresp <= antenna_supervisor_pkg::AXI_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* antenna_supervisor_checker.sv */
`timescale 1ns/1ps
module antenna_supervisor_checker #(
  parameter int RECOVERY_CYCLES = 20
) (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        antenna_short_in,
  input wire logic        antenna_power_off
);
  logic [2:0] since_low;
  int         off_count;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // cycles since the short line was last low, saturating so it never wraps
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      since_low <= 3'h7;
    end else if (!antenna_short_in) begin
      since_low <= 3'h0;
    end else if (since_low != 3'h7) begin
      since_low <= since_low + 3'h1;
    end
  end

  // length of the current power-off spell
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      off_count <= 0;
    end else begin
      off_count <= antenna_power_off ? off_count + 1 : 0;
    end
  end

  chk_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while a response is pending");
  chk_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while read data is pending");
  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before acceptance");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
                                   && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped or changed before acceptance");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not presented the cycle after the address");
  chk_power_cause: assert property ($rose(antenna_power_off) |-> since_low <= 3'h5)
    else $error("power removed without a recent short on the sense line");
  chk_off_length: assert property ($fell(antenna_power_off) |->
                                   off_count >= RECOVERY_CYCLES - 1 && off_count <= RECOVERY_CYCLES + 1)
    else $error("power-off spell does not match the recovery timeout");
  chk_retest_gap: assert property ($fell(antenna_power_off) |-> !antenna_power_off [*8])
    else $error("power removed again before the re-test settle time");
  chk_release_quiet: assert property ($rose(rst_b) |-> !antenna_power_off [*4])
    else $error("antenna power removed right after reset");
endmodule

bind antenna_supervisor antenna_supervisor_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) checker_i (
  .clock, .rst_b, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .antenna_short_in, .antenna_power_off
);

/* antenna_supervisor_pkg.sv */
package antenna_supervisor_pkg;
  // register byte offsets
  localparam logic [7:0] CONFIG_OFFSET     = 8'h00;
  localparam logic [7:0] STATUS_OFFSET     = 8'h04;
  localparam logic [7:0] EVENT_OFFSET      = 8'h08;
  localparam logic [7:0] MASK_OFFSET       = 8'h0C;
  localparam logic [7:0] FEATURE_OFFSET    = 8'h10;
  localparam logic [7:0] REPORT_OFFSET     = 8'h14;

  // config bit positions
  localparam int CFG_VOLTAGE_BIT  = 0;
  localparam int CFG_SHORT_BIT    = 1;
  localparam int CFG_RECOVERY_BIT = 2;
  localparam int CFG_OPEN_BIT     = 3;
  localparam logic [3:0] CONFIG_RESET = 4'h0;

  // status register layout
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_POWER_BIT = 4;
  localparam int STATUS_VALID_BIT = 5;

  // feature report bits
  localparam int FEAT_CONTROL_BIT  = 0;
  localparam int FEAT_SHORT_BIT    = 1;
  localparam int FEAT_OPEN_BIT     = 2;
  localparam int FEAT_FEATURE_POWER_DOWN_ON_SHORT_BIT     = 3;
  localparam int FEAT_RECOVERY_BIT = 4;

  // event bits
  localparam int EV_STATUS_CHANGE = 0;
  localparam int EV_SHORT         = 1;
  localparam int EV_OPEN          = 2;
  localparam int EV_RECOVERED     = 3;
  localparam int EVENT_WIDTH      = 4;

  // antenna status codes
  typedef enum logic [1:0] {
    ANT_INIT  = 2'h0,
    ANT_OK    = 2'h1,
    ANT_SHORT = 2'h3,
    ANT_OPEN  = 2'h2
  } antenna_status_type;

  // recovery sequence states, gray along idle -> off -> retest
  typedef enum logic [1:0] {
    REC_IDLE   = 2'h0,
    REC_OFF    = 2'h1,
    REC_RETEST = 2'h3
  } recovery_state_type;

  // timing: re-test timeout
  localparam int CLOCK_MHZ          = 125;
  localparam int RECOVERY_TIMEOUT_MS = 1000;
  localparam int RECOVERY_CYCLES    = RECOVERY_TIMEOUT_MS * 1000 * CLOCK_MHZ;
  localparam int INIT_CYCLES        = 2;
  localparam int RETEST_SETTLE      = 4;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

/* tb_antenna_supervisor.sv */
`timescale 1ns/1ps
module tb_antenna_supervisor;
  localparam int REC = 20;
  logic        clock;
  logic        rst_b;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, data, pick;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        antenna_short_in, antenna_present_in, antenna_power_off, interrupt;
  logic        short_fault, open_fault, slow;
  int          failures, comparisons, cycles, seed, i;

  antenna_supervisor #(.RECOVERY_CYCLES(REC)) dut (
    .clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .antenna_short_in, .antenna_present_in,
    .antenna_power_off, .interrupt
  );
  antenna_sense_model model (
    .clock, .antenna_power_off, .short_fault, .open_fault, .slow, .antenna_short_in,
    .antenna_present_in
  );

  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // both channels offered together; each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check(name, data, exp);
  endtask

  function automatic logic [31:0] st(input antenna_supervisor_pkg::antenna_status_type c,
                                     input logic p);
    st = {30'h0, c};
    st[antenna_supervisor_pkg::STATUS_VALID_BIT] = 1'b1;
    st[antenna_supervisor_pkg::STATUS_POWER_BIT] = p;
  endfunction

  // features only show once control is on; recovery implies power-down-on-short
  function automatic logic [31:0] feat(input logic [3:0] c);
    feat = 32'h0;
    feat[antenna_supervisor_pkg::FEAT_CONTROL_BIT]  = c[0];
    feat[antenna_supervisor_pkg::FEAT_SHORT_BIT]    = c[0] & c[1];
    feat[antenna_supervisor_pkg::FEAT_OPEN_BIT]     = c[0] & c[3];
    feat[antenna_supervisor_pkg::FEAT_FEATURE_POWER_DOWN_ON_SHORT_BIT]     = c[0] & c[2];
    feat[antenna_supervisor_pkg::FEAT_RECOVERY_BIT] = c[0] & c[2];
  endfunction

  task automatic configure(input logic [3:0] c);
    axi_write(antenna_supervisor_pkg::CONFIG_OFFSET, {28'h0, c});
    repeat (12) @(posedge clock);
    rd_check("features", antenna_supervisor_pkg::FEATURE_OFFSET, feat(c));
  endtask

  // bounded wait for the power-off pin to reach a level
  task automatic wait_off(input logic v);
    int n;
    n = 0;
    while (antenna_power_off !== v && n < 100) begin
      @(posedge clock);
      n++;
    end
    check("power_off", {31'h0, antenna_power_off}, {31'h0, v});
  endtask

  initial begin
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {short_fault, open_fault, slow} = '0;
    seed = 62;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    rd_check("status", antenna_supervisor_pkg::STATUS_OFFSET, 32'h0);
    rd_check("features", antenna_supervisor_pkg::FEATURE_OFFSET, 32'h0);
    rd_check("reports", antenna_supervisor_pkg::REPORT_OFFSET, 0);
    check("power_off", {31'h0, antenna_power_off}, 32'h0);
    axi_read(8'h18);
    check("unmapped rdata", data, 32'h0);
    check("unmapped rresp", {30'h0, resp}, {30'h0, antenna_supervisor_pkg::AXI_SLVERR});
    axi_write(8'h1C, 32'hFFFFFFFF);
    check("unmapped bresp", {30'h0, resp}, {30'h0, antenna_supervisor_pkg::AXI_SLVERR});
    // control only: a short is ignored while detection is off
    configure(4'h1);
    rd_check("status", antenna_supervisor_pkg::STATUS_OFFSET, st(antenna_supervisor_pkg::ANT_OK, 1'b1));
    short_fault <= 1'b1;
    repeat (12) @(posedge clock);
    rd_check("status", antenna_supervisor_pkg::STATUS_OFFSET, st(antenna_supervisor_pkg::ANT_OK, 1'b1));
    short_fault <= 1'b0;
    axi_write(antenna_supervisor_pkg::EVENT_OFFSET, 32'hF);
    axi_write(antenna_supervisor_pkg::MASK_OFFSET, 32'h2);
    // short detect without recovery keeps the antenna powered
    configure(4'h3);
    short_fault <= 1'b1;
    repeat (12) @(posedge clock);
    rd_check("status", antenna_supervisor_pkg::STATUS_OFFSET, st(antenna_supervisor_pkg::ANT_SHORT, 1'b1));
    check("power_off", {31'h0, antenna_power_off}, 32'h0);
    check("interrupt", {31'h0, interrupt}, 32'h1);
    short_fault <= 1'b0;
    repeat (12) @(posedge clock);
    rd_check("status", antenna_supervisor_pkg::STATUS_OFFSET, st(antenna_supervisor_pkg::ANT_SHORT, 1'b1));
    axi_write(antenna_supervisor_pkg::MASK_OFFSET, 32'h0);
    repeat (3) @(posedge clock);
    check("interrupt", {31'h0, interrupt}, 32'h0);
    axi_write(antenna_supervisor_pkg::EVENT_OFFSET, 32'h2);
    axi_write(antenna_supervisor_pkg::MASK_OFFSET, 32'h2);
    repeat (3) @(posedge clock);
    check("interrupt", {31'h0, interrupt}, 32'h0);
    configure(4'h1);
    configure(4'h3);
    rd_check("status", antenna_supervisor_pkg::STATUS_OFFSET, st(antenna_supervisor_pkg::ANT_OK, 1'b1));
    // recovery: shut down, re-test while still shorted, then recover
    configure(4'h7);
    axi_write(antenna_supervisor_pkg::EVENT_OFFSET, 32'hF);
    short_fault <= 1'b1;
    repeat (12) @(posedge clock);
    check("power_off", {31'h0, antenna_power_off}, 32'h1);
    rd_check("status", antenna_supervisor_pkg::STATUS_OFFSET, st(antenna_supervisor_pkg::ANT_SHORT, 1'b0));
    slow <= 1'b1;
    wait_off(1'b0);
    wait_off(1'b1);
    short_fault <= 1'b0;
    wait_off(1'b0);
    repeat (REC) @(posedge clock);
    check("power_off", {31'h0, antenna_power_off}, 32'h0);
    rd_check("status", antenna_supervisor_pkg::STATUS_OFFSET, st(antenna_supervisor_pkg::ANT_OK, 1'b1));
    axi_read(antenna_supervisor_pkg::EVENT_OFFSET);
    check("recovered event", data & 32'h8, 32'h8);
    // random open states and mask values
    configure(4'hF);
    for (i = 0; i < 8; i++) begin
      pick = $random(seed);
      open_fault <= pick[0];
      repeat (12 + pick[10:8]) @(posedge clock);
      rd_check("status", antenna_supervisor_pkg::STATUS_OFFSET, st(pick[0] ?
               antenna_supervisor_pkg::ANT_OPEN : antenna_supervisor_pkg::ANT_OK, 1'b1));
      axi_write(antenna_supervisor_pkg::MASK_OFFSET, {28'h0, pick[7:4]});
      rd_check("mask", antenna_supervisor_pkg::MASK_OFFSET, {28'h0, pick[7:4]});
    end
    open_fault <= 1'b0;
    axi_write(antenna_supervisor_pkg::STATUS_OFFSET, 32'h0);
    repeat (12) @(posedge clock);
    rd_check("status", antenna_supervisor_pkg::STATUS_OFFSET, st(antenna_supervisor_pkg::ANT_OK, 1'b1));
    rd_check("config", antenna_supervisor_pkg::CONFIG_OFFSET, 32'hF);
    results();
  end
endmodule
